// file: logic/ccs_pkg.sv
// Behaviour
// - lock bit 14 of global setup blocks register modification
// - unlock field is trigger bits 15-12; only 0101 arms unlocking
// - input converter power field bits 11-10 selects four power modes
// - second output power field bits 2-1 selects four power modes
// - global setup sits at 1Fh and resets to 03F9h
// - trigger register sits at 20h and resets to 0000h
// - 1010 in trigger bits 11-8 causes full reset; field self-clears
// - trigger bit 1 starts storing settings; bit clears itself
// - trigger bit 0 reloads stored settings; bit clears itself
// - pwm run at 21h resets 0001h; machine sets, zero write halts
// - status bit 15 flags factory load crc failure; reset clears it
// - status bit 14 flags user load crc failure; soft reset clears
// - status bits 12 and 9 show channel zero and one busy
// - status bit 8 shows nonvolatile memory unavailable
// - status at 22h holds part id in 7-2 and zero revision
// - registers are sixteen bits at the listed serial addresses
`default_nettype none

package ccs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  localparam logic [7:0] ADDR_GLOBAL_SETUP = 8'h1f;
  localparam logic [7:0] ADDR_ACTION_TRIGGER = 8'h20;
  localparam logic [7:0] ADDR_PWM_RUN_CONTROL = 8'h21;
  localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h22;

  localparam logic [15:0] RST_GLOBAL_SETUP = 16'h03f9;
  localparam logic [15:0] RST_ACTION_TRIGGER = 16'h0000;
  localparam logic [15:0] RST_PWM_RUN_CONTROL = 16'h0001;

  localparam int unsigned LOCK_BIT = 14;
  localparam int unsigned INT_REF_BIT = 12;
  localparam int unsigned CONV_PWR_LSB = 10;
  localparam int unsigned OUT1_PWR_LSB = 1;
  localparam int unsigned UNLOCK_LSB = 12;
  localparam int unsigned RESET_LSB = 8;
  localparam int unsigned PROG_BIT = 1;
  localparam int unsigned RELOAD_BIT = 0;
  localparam int unsigned PWM_RUN_BIT = 0;
  localparam int unsigned ST_FACTORY_CRC = 15;
  localparam int unsigned ST_USER_CRC = 14;
  localparam int unsigned ST_FIXED_ONE = 13;
  localparam int unsigned ST_CH0_BUSY = 12;
  localparam int unsigned ST_CH1_BUSY = 9;
  localparam int unsigned ST_STORE_BUSY = 8;
  localparam int unsigned ST_PART_LSB = 2;

  localparam logic [3:0] UNLOCK_KEY = 4'h5;
  localparam logic [3:0] SOFT_RESET_KEY = 4'ha;
  localparam logic [1:0] REVISION_VALUE = 2'h0;

  // soft reset request held toward the rest of the device
  localparam int unsigned SRST_TIME_NS = 160;
  localparam int unsigned SRST_CYCLES =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CCS_IDLE = 3'b001,
    CCS_PROG = 3'b010,
    CCS_LOAD = 3'b100
  } ccs_nvm_state_t;

  function automatic logic ccs_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    ccs_hit = (addr == target);
  endfunction : ccs_hit

endpackage : ccs_pkg

`default_nettype wire

// file: logic/ccs_nvm_seq.sv
`default_nettype none

module ccs_nvm_seq
  import ccs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic abort,
  input wire logic prog_req,
  input wire logic reload_req,
  input wire logic nvm_done,
  input wire logic nvm_crc_err,
  output logic prog_start,
  output logic reload_start,
  output logic busy,
  output logic prog_pending,
  output logic reload_pending,
  output logic load_ok,
  output logic load_fail
);

  ccs_nvm_state_t state_q, state_d;
  logic idle;

  assign idle = (state_q == CCS_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      CCS_IDLE: begin
        // store has priority when both triggers arrive together
        if (!abort && prog_req) begin
          state_d = CCS_PROG;
        end else if (!abort && reload_req) begin
          state_d = CCS_LOAD;
        end
      end
      CCS_PROG, CCS_LOAD: begin
        if (abort || nvm_done) begin
          state_d = CCS_IDLE;
        end
      end
      default: begin
        state_d = CCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CCS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign prog_start = idle && !abort && prog_req;
  assign reload_start = idle && !abort && !prog_req && reload_req;
  assign busy = !idle;
  assign prog_pending = (state_q == CCS_PROG);
  assign reload_pending = (state_q == CCS_LOAD);
  assign load_ok = reload_pending && nvm_done && !nvm_crc_err && !abort;
  assign load_fail = reload_pending && nvm_done && nvm_crc_err && !abort;

endmodule : ccs_nvm_seq

`default_nettype wire

// file: logic/ccs_rst_gen.sv
`default_nettype none

module ccs_rst_gen
  import ccs_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = SRST_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic trigger,
  output logic por_request
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (trigger) begin
      cnt_d = CW'(HOLD_CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign por_request = (cnt_q != '0);

endmodule : ccs_rst_gen

`default_nettype wire

// file: logic/ccs_common_regs.sv
`default_nettype none

module ccs_common_regs
  import ccs_pkg::*;
#(
  // arbitrary neutral identifier value
  parameter logic [5:0] PART_ID = 6'h2a,
  parameter int unsigned SRST_HOLD = SRST_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sm_pwm_set,
  input wire logic ch0_busy,
  input wire logic ch1_busy,
  input wire logic otp_load_done,
  input wire logic otp_crc_err,
  input wire logic nvm_done,
  input wire logic nvm_crc_err,
  input wire logic [15:0] nvm_load_data,
  output logic store_program_trigger_start,
  output logic store_reload_trigger_start,
  output logic [15:0] nvm_store_data,
  output logic int_ref_en,
  output logic [1:0] input_conv_power_sel,
  output logic [1:0] out1_power_sel,
  output logic register_lock_bit,
  output logic pwm_run,
  output logic store_busy_flag,
  output logic por_request
);

  logic [15:0] global_setup_q, global_setup_d;
  logic unlock_armed_q, unlock_armed_d;
  logic pwm_run_q, pwm_run_d;
  logic factory_crc_q, factory_crc_d;
  logic user_crc_q, user_crc_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  logic wr_setup, wr_trig, wr_pwm;
  logic locked, key_ok;
  logic srst_go, prog_req, reload_req;
  logic busy, prog_pending, reload_pending;
  logic load_ok, load_fail;
  logic [15:0] trig_view, pwm_view, status_view;

  // decode of serial register writes

  assign wr_setup = reg_wr && ccs_hit(reg_addr, ADDR_GLOBAL_SETUP);
  assign wr_trig = reg_wr && ccs_hit(reg_addr, ADDR_ACTION_TRIGGER);
  assign wr_pwm = reg_wr && ccs_hit(reg_addr, ADDR_PWM_RUN_CONTROL);

  assign locked = global_setup_q[LOCK_BIT];
  assign key_ok = (reg_wdata[UNLOCK_LSB +: 4] == UNLOCK_KEY);

  // a soft reset outranks store and reload in the same write
  assign srst_go = wr_trig && !locked &&
                   (reg_wdata[RESET_LSB +: 4] == SOFT_RESET_KEY);
  assign prog_req = wr_trig && !locked && !srst_go &&
                    reg_wdata[PROG_BIT];
  assign reload_req = wr_trig && !locked && !srst_go &&
                      reg_wdata[RELOAD_BIT];

  // store / reload sequencing; a trigger while busy is dropped

  ccs_nvm_seq u_nvm_seq (
    .clk(clk),
    .rstn(rstn),
    .abort(srst_go),
    .prog_req(prog_req),
    .reload_req(reload_req),
    .nvm_done(nvm_done),
    .nvm_crc_err(nvm_crc_err),
    .prog_start(store_program_trigger_start),
    .reload_start(store_reload_trigger_start),
    .busy(busy),
    .prog_pending(prog_pending),
    .reload_pending(reload_pending),
    .load_ok(load_ok),
    .load_fail(load_fail)
  );

  ccs_rst_gen #(
    .HOLD_CYCLES(SRST_HOLD)
  ) u_rst_gen (
    .clk(clk),
    .rstn(rstn),
    .trigger(srst_go),
    .por_request(por_request)
  );

  // global setup and lock

  always_comb begin
    global_setup_d = global_setup_q;
    unlock_armed_d = unlock_armed_q;
    if (srst_go) begin
      global_setup_d = RST_GLOBAL_SETUP;
      unlock_armed_d = 1'b0;
    end else if (load_ok) begin
      global_setup_d = nvm_load_data;
    end else if (wr_setup) begin
      if (!locked) begin
        // reserved fields are stored as written; host keeps them
        global_setup_d = reg_wdata;
      end else if (unlock_armed_q && !reg_wdata[LOCK_BIT]) begin
        // only the lock bit moves while locked
        global_setup_d[LOCK_BIT] = 1'b0;
        unlock_armed_d = 1'b0;
      end
    end
    // the key counts only while locked, so a stale key cannot linger
    if (!srst_go && wr_trig && locked && key_ok) begin
      unlock_armed_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      global_setup_q <= RST_GLOBAL_SETUP;
      unlock_armed_q <= 1'b0;
    end else begin
      global_setup_q <= global_setup_d;
      unlock_armed_q <= unlock_armed_d;
    end
  end

  assign register_lock_bit = global_setup_q[LOCK_BIT];
  assign int_ref_en = global_setup_q[INT_REF_BIT];
  assign input_conv_power_sel = global_setup_q[CONV_PWR_LSB +: 2];
  assign out1_power_sel = global_setup_q[OUT1_PWR_LSB +: 2];
  assign nvm_store_data = global_setup_q;

  // pwm run flag: the machine's set wins over a host clear

  always_comb begin
    pwm_run_d = pwm_run_q;
    if (srst_go) begin
      pwm_run_d = RST_PWM_RUN_CONTROL[PWM_RUN_BIT];
    end else if (sm_pwm_set) begin
      pwm_run_d = 1'b1;
    end else if (wr_pwm && !locked && !reg_wdata[PWM_RUN_BIT]) begin
      pwm_run_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_run_q <= RST_PWM_RUN_CONTROL[PWM_RUN_BIT];
    end else begin
      pwm_run_q <= pwm_run_d;
    end
  end

  assign pwm_run = pwm_run_q;

  // crc failure flags; a factory failure in the reset cycle still sticks, a user one is dropped

  always_comb begin
    factory_crc_d = (factory_crc_q && !srst_go) ||
                    (otp_load_done && otp_crc_err);
    user_crc_d = (user_crc_q && !srst_go) || load_fail;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      factory_crc_q <= 1'b0;
      user_crc_q <= 1'b0;
    end else begin
      factory_crc_q <= factory_crc_d;
      user_crc_q <= user_crc_d;
    end
  end

  assign store_busy_flag = busy;

  // read views

  always_comb begin
    trig_view = RST_ACTION_TRIGGER;
    // trigger bits read back one until the operation finishes
    trig_view[PROG_BIT] = prog_pending;
    trig_view[RELOAD_BIT] = reload_pending;
    pwm_view = 16'h0000;
    pwm_view[PWM_RUN_BIT] = pwm_run_q;
    status_view = 16'h0000;
    status_view[ST_FACTORY_CRC] = factory_crc_q;
    status_view[ST_USER_CRC] = user_crc_q;
    status_view[ST_FIXED_ONE] = 1'b1;
    status_view[ST_CH0_BUSY] = ch0_busy;
    status_view[ST_CH1_BUSY] = ch1_busy;
    status_view[ST_STORE_BUSY] = busy;
    status_view[ST_PART_LSB +: 6] = PART_ID;
    status_view[1:0] = REVISION_VALUE;
  end

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      // unmapped addresses answer zero
      rdata_d = 16'h0000;
      if (ccs_hit(reg_addr, ADDR_GLOBAL_SETUP)) begin
        rdata_d = global_setup_q;
      end else if (ccs_hit(reg_addr, ADDR_ACTION_TRIGGER)) begin
        rdata_d = trig_view;
      end else if (ccs_hit(reg_addr, ADDR_PWM_RUN_CONTROL)) begin
        rdata_d = pwm_view;
      end else if (ccs_hit(reg_addr, ADDR_DEVICE_STATUS)) begin
        rdata_d = status_view;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_lock_holds;
    wr_setup && locked && !unlock_armed_q && !load_ok && !srst_go
      |=> $stable(global_setup_q);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("locked setup register changed");

  property p_bad_key;
    wr_trig && !key_ok && !unlock_armed_q |=> !unlock_armed_q;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("non-key value armed unlock");

  property p_unlock_seq;
    // the host may leave idle cycles between key and lock clear
    wr_trig && locked && key_ok && !srst_go ##[1:4]
      wr_setup && !reg_wdata[LOCK_BIT] && !load_ok
      |=> !register_lock_bit;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq)
    else $error("unlock sequence failed to clear lock");

  property p_conv_pwr;
    wr_setup && !locked && !srst_go && !load_ok
      |=> input_conv_power_sel == $past(reg_wdata[11:10]) &&
          out1_power_sel == $past(reg_wdata[2:1]);
  endproperty
  a_conv_pwr: assert property (p_conv_pwr)
    else $error("power select not taken from write");

  property p_srst_values;
    srst_go |=> global_setup_q == RST_GLOBAL_SETUP &&
                trig_view == RST_ACTION_TRIGGER && pwm_run_q;
  endproperty
  a_srst_values: assert property (p_srst_values)
    else $error("soft reset left registers off reset value");

  property p_srst_hold;
    srst_go |=> por_request [*4];
  endproperty
  a_srst_hold: assert property (p_srst_hold)
    else $error("reset request not held");

  property p_prog_start;
    prog_req && !busy |-> store_program_trigger_start ##1 (store_busy_flag &&
                          trig_view[PROG_BIT]);
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("store trigger not started");

  property p_reload_copy;
    load_ok && !srst_go |=> global_setup_q == $past(nvm_load_data) &&
                            !trig_view[RELOAD_BIT];
  endproperty
  a_reload_copy: assert property (p_reload_copy)
    else $error("reload data not copied");

  property p_pwm_set;
    sm_pwm_set |=> pwm_run ##1 (pwm_run || $past(wr_pwm));
  endproperty
  a_pwm_set: assert property (p_pwm_set)
    else $error("pwm run not set by machine");

  property p_user_crc;
    load_fail |=> user_crc_q ##1 (user_crc_q || $past(srst_go));
  endproperty
  a_user_crc: assert property (p_user_crc)
    else $error("user crc flag not held");

  property p_status_read;
    reg_rd && ccs_hit(reg_addr, ADDR_DEVICE_STATUS)
      |=> reg_rvalid && reg_rdata[7:2] == PART_ID &&
          reg_rdata[1:0] == 2'h0;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status identifier wrong");

  property p_ch_busy;
    reg_rd && ccs_hit(reg_addr, ADDR_DEVICE_STATUS)
      |=> reg_rdata[ST_CH0_BUSY] == $past(ch0_busy) &&
          reg_rdata[ST_CH1_BUSY] == $past(ch1_busy);
  endproperty
  a_ch_busy: assert property (p_ch_busy)
    else $error("channel busy status wrong");

  property p_factory_crc;
    otp_load_done && otp_crc_err |=> factory_crc_q;
  endproperty
  a_factory_crc: assert property (p_factory_crc)
    else $error("factory crc failure not flagged");

  property p_pwm_halt;
    wr_pwm && !locked && !reg_wdata[PWM_RUN_BIT] && !sm_pwm_set
      |=> !pwm_run;
  endproperty
  a_pwm_halt: assert property (p_pwm_halt)
    else $error("pwm run not halted by host write");

  property p_read_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered in next cycle");

  c_unlock: cover property (p_unlock_seq);
  c_reload_ok: cover property (load_ok ##1 !store_busy_flag);
  c_srst: cover property (srst_go ##5 !por_request);
  c_pwm_halt: cover property (pwm_run ##1 !pwm_run);

endmodule : ccs_common_regs

`default_nettype wire

// file: tb/ccs_common_regs_bench.sv
`default_nettype none

module ccs_common_regs_bench
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rstn;
  logic reg_wr, reg_rd, sm_pwm_set, ch0_busy, ch1_busy;
  logic otp_load_done, otp_crc_err, nvm_done, nvm_crc_err;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, nvm_load_data, reg_rdata, nvm_store_data;
  logic reg_rvalid, store_program_trigger_start, store_reload_trigger_start, int_ref_en;
  logic [1:0] input_conv_power_sel, out1_power_sel;
  logic register_lock_bit, pwm_run, store_busy_flag, por_request;
  logic st_prog, st_rel;
  int bad_count = 0;
  int checked = 0;

  always #20 clk = ~clk;

  ccs_common_regs #(.SRST_HOLD(4)) DUT (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sm_pwm_set(sm_pwm_set),
    .ch0_busy(ch0_busy), .ch1_busy(ch1_busy),
    .otp_load_done(otp_load_done), .otp_crc_err(otp_crc_err),
    .nvm_done(nvm_done), .nvm_crc_err(nvm_crc_err),
    .nvm_load_data(nvm_load_data), .store_program_trigger_start(store_program_trigger_start),
    .store_reload_trigger_start(store_reload_trigger_start), .nvm_store_data(nvm_store_data),
    .int_ref_en(int_ref_en), .input_conv_power_sel(input_conv_power_sel),
    .out1_power_sel(out1_power_sel),
    .register_lock_bit(register_lock_bit), .pwm_run(pwm_run),
    .store_busy_flag(store_busy_flag), .por_request(por_request)
  );

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // start pulses are combinational, so they are caught mid-cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge clk);
    st_prog = store_program_trigger_start;
    st_rel = store_reload_trigger_start;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic ck_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check("rvalid", {15'h0000, reg_rvalid}, 16'h0001);
    check("rdata", reg_rdata, exp);
  endtask : ck_rd

  task automatic done_pulse(input logic err);
    @(posedge clk);
    nvm_done <= 1'b1;
    nvm_crc_err <= err;
    @(posedge clk);
    nvm_done <= 1'b0;
    nvm_crc_err <= 1'b0;
    @(negedge clk);
  endtask : done_pulse

  task automatic t_reset;
    check("outs", {7'h00, int_ref_en, input_conv_power_sel, out1_power_sel,
      register_lock_bit, pwm_run, store_busy_flag, por_request},
      16'h0004);
    ck_rd(8'h1f, 16'h03f9);
    ck_rd(8'h20, 16'h0000);
    ck_rd(8'h21, 16'h0001);
    ck_rd(8'h22, 16'h20a8);
    ck_rd(8'h23, 16'h0000);
    wr(8'h22, 16'hffff);
    ck_rd(8'h22, 16'h20a8);
  endtask : t_reset

  task automatic t_fields;
    logic [15:0] d;
    for (int v = 0; v < 4; v++) begin
      d = 16'h13f9 | (16'(v) << 10) | (16'(v) << 1);
      wr(8'h1f, d);
      check("conv", {14'h0000, input_conv_power_sel}, 16'(v));
      check("out1", {14'h0000, out1_power_sel}, 16'(v));
      check("iref", {15'h0000, int_ref_en}, 16'h0001);
      ck_rd(8'h1f, d);
    end
    wr(8'h1f, 16'h03f9);
    check("iref", {15'h0000, int_ref_en}, 16'h0000);
  endtask : t_fields

  task automatic t_lock;
    wr(8'h1f, 16'h43f9);
    check("lock", {15'h0000, register_lock_bit}, 16'h0001);
    wr(8'h1f, 16'h07f9);
    check("conv", {14'h0000, input_conv_power_sel}, 16'h0000);
    wr(8'h21, 16'h0000);
    check("pwm", {15'h0000, pwm_run}, 16'h0001);
    wr(8'h20, 16'h6000);
    wr(8'h1f, 16'h03f9);
    check("lock", {15'h0000, register_lock_bit}, 16'h0001);
    wr(8'h20, 16'h5000);
    wr(8'h1f, 16'h03f9);
    check("lock", {15'h0000, register_lock_bit}, 16'h0000);
    ck_rd(8'h1f, 16'h03f9);
  endtask : t_lock

  task automatic t_store;
    // store outranks a reload written in the same word
    wr(8'h20, 16'h0003);
    check("prog", {15'h0000, st_prog}, 16'h0001);
    check("rel", {15'h0000, st_rel}, 16'h0000);
    check("busy", {15'h0000, store_busy_flag}, 16'h0001);
    check("store", nvm_store_data, 16'h03f9);
    ck_rd(8'h20, 16'h0002);
    ck_rd(8'h22, 16'h21a8);
    done_pulse(1'b0);
    check("busy", {15'h0000, store_busy_flag}, 16'h0000);
    ck_rd(8'h20, 16'h0000);
  endtask : t_store

  task automatic t_pwm;
    wr(8'h21, 16'h0000);
    check("pwm", {15'h0000, pwm_run}, 16'h0000);
    wr(8'h21, 16'h0000);
    check("pwm", {15'h0000, pwm_run}, 16'h0000);
    ck_rd(8'h21, 16'h0000);
    @(posedge clk);
    sm_pwm_set <= 1'b1;
    @(posedge clk);
    sm_pwm_set <= 1'b0;
    @(negedge clk);
    check("pwm", {15'h0000, pwm_run}, 16'h0001);
    // machine set and host clear in one cycle: the set wins
    @(posedge clk);
    sm_pwm_set <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= 8'h21;
    reg_wdata <= 16'h0000;
    @(posedge clk);
    sm_pwm_set <= 1'b0;
    reg_wr <= 1'b0;
    @(negedge clk);
    check("pwm", {15'h0000, pwm_run}, 16'h0001);
  endtask : t_pwm

  task automatic t_status;
    @(posedge clk);
    ch0_busy <= 1'b1;
    ck_rd(8'h22, 16'h30a8);
    @(posedge clk);
    ch0_busy <= 1'b0;
    ch1_busy <= 1'b1;
    ck_rd(8'h22, 16'h22a8);
    @(posedge clk);
    ch1_busy <= 1'b0;
    otp_load_done <= 1'b1;
    otp_crc_err <= 1'b1;
    @(posedge clk);
    otp_load_done <= 1'b0;
    otp_crc_err <= 1'b0;
    ck_rd(8'h22, 16'ha0a8);
  endtask : t_status

  task automatic t_reload;
    @(posedge clk);
    nvm_load_data <= 16'h0bf9;
    wr(8'h20, 16'h0001);
    check("rel", {15'h0000, st_rel}, 16'h0001);
    done_pulse(1'b0);
    check("conv", {14'h0000, input_conv_power_sel}, 16'h0002);
    ck_rd(8'h20, 16'h0000);
    ck_rd(8'h1f, 16'h0bf9);
    check("busy", {15'h0000, store_busy_flag}, 16'h0000);
    wr(8'h20, 16'h0001);
    done_pulse(1'b1);
    ck_rd(8'h22, 16'he0a8);
    // the failure flag does not block ordinary writes
    wr(8'h1f, 16'h07f9);
    check("conv", {14'h0000, input_conv_power_sel}, 16'h0001);
  endtask : t_reload

  task automatic t_soft;
    int n;
    wr(8'h20, 16'h0b00);
    check("por", {15'h0000, por_request}, 16'h0000);
    ck_rd(8'h1f, 16'h07f9);
    wr(8'h20, 16'h0a00);
    n = 0;
    repeat (8) begin
      if (por_request === 1'b1) n++;
      @(negedge clk);
    end
    check("por_len", 16'(n), 16'h0004);
    ck_rd(8'h1f, 16'h03f9);
    ck_rd(8'h20, 16'h0000);
    ck_rd(8'h22, 16'h20a8);
  endtask : t_soft

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("wrong value watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, sm_pwm_set, ch0_busy, ch1_busy} = 5'h00;
    {otp_load_done, otp_crc_err, nvm_done, nvm_crc_err} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    nvm_load_data = 16'h0000;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_fields();
    t_lock();
    t_store();
    t_pwm();
    t_status();
    t_reload();
    t_soft();
    conclude();
  end

endmodule : ccs_common_regs_bench

`default_nettype wire
